// [coc_pkg.sv]
/*
 * Shared constants and types for the cursor overlay control block:
 * register indices, field positions, reset values, pixel carrier.
 * Assumes an APB bus with 32-bit data; each register index sits at
 * byte address four times the index.
 */
package coc_pkg;

   // register indices, byte address is index * 4
   localparam logic [6:0] COC_IDX_SCAN  = 7'h12;
   localparam logic [6:0] COC_IDX_CTRL  = 7'h3C;
   localparam logic [6:0] COC_IDX_BLINK = 7'h3D;
   localparam logic [6:0] COC_IDX_TW    = 7'h3E;
   localparam logic [6:0] COC_IDX_TH    = 7'h3F;
   localparam logic [6:0] COC_IDX_XL    = 7'h40;
   localparam logic [6:0] COC_IDX_XH    = 7'h41;
   localparam logic [6:0] COC_IDX_YL    = 7'h42;
   localparam logic [6:0] COC_IDX_YH    = 7'h43;
   localparam logic [6:0] COC_IDX_CA    = 7'h44;
   localparam logic [6:0] COC_IDX_CB    = 7'h45;
   localparam logic [6:0] COC_IDX_ENL   = 7'h48;
   localparam logic [6:0] COC_IDX_STAT  = 7'h49;

   // field positions
   localparam int COC_CTRL_BLINK_EN = 0;
   localparam int COC_CTRL_TXT_EN   = 1;
   localparam int COC_CTRL_SEL_LO   = 2;
   localparam int COC_CTRL_GFX_EN   = 4;
   localparam int COC_SCAN_VREV     = 3;
   localparam int COC_ENL_H_LO      = 0;
   localparam int COC_ENL_V_LO      = 2;

   // reset values
   localparam logic [7:0] COC_RST_BLINK = 8'h00;
   localparam logic [4:0] COC_RST_TW    = 5'h07;
   localparam logic [4:0] COC_RST_TH    = 5'h00;
   localparam logic [12:0] COC_RST_POS  = 13'h0000;
   localparam logic [7:0] COC_RST_COL   = 8'h00;

   // graphic cursor is a fixed square
   localparam logic [12:0] COC_GFX_DIM = 13'h0020;

   // shape codes from the shape generator
   localparam logic [1:0] COC_SHP_NONE = 2'h0;
   localparam logic [1:0] COC_SHP_A    = 2'h1;
   localparam logic [1:0] COC_SHP_B    = 2'h2;

   typedef enum logic [1:0] {
      COC_SET_ARROW = 2'b00,
      COC_SET_CROSS = 2'b01,
      COC_SET_FRAME = 2'b10,
      COC_SET_BLOCK = 2'b11
   } coc_shape_t;

   // one pixel of the display stream
   typedef struct packed {
      logic        valid;
      logic [12:0] x;
      logic [12:0] y;
      logic [7:0]  rgb;
   } coc_pix_t;

endpackage

// [coc_shape.sv]
/*
 * Graphic cursor shape generator: maps an offset inside the 32x32
 * cursor square to transparent, colour a or colour b.
 * Assumes offsets are already known to lie inside the square.
 */
`timescale 1ns/1ps
module coc_shape
   import coc_pkg::*;
(
   input  wire logic [4:0] dx,
   input  wire coc_shape_t sel,
   input  wire logic [4:0] dy,
   output logic      [1:0] code
);

   logic edge_box;
   logic mid_col;
   logic mid_row;

   // borders and centre lines used by the cross, frame and block sets
   assign edge_box = (dx == 5'h00) || (dx == 5'h1F) || (dy == 5'h00) || (dy == 5'h1F);
   assign mid_col  = (dx == 5'h0F) || (dx == 5'h10);
   assign mid_row  = (dy == 5'h0F) || (dy == 5'h10);

   // shape lookup, drawn procedurally rather than stored
   always_comb
   begin
      code = COC_SHP_NONE;
      unique case (sel)
         COC_SET_ARROW:
         begin
            if (dx <= dy)
               code = ((dx == 5'h00) || (dx == dy) || (dy == 5'h1F)) ? COC_SHP_B : COC_SHP_A;
         end
         COC_SET_CROSS:
         begin
            if (mid_col || mid_row)
               code = COC_SHP_A;
         end
         COC_SET_FRAME:
         begin
            if (edge_box)
               code = COC_SHP_B;
         end
         COC_SET_BLOCK:
         begin
            code = edge_box ? COC_SHP_B : COC_SHP_A;
         end
      endcase
   end

endmodule // coc_shape

// [coc_cursor_overlay.sv]
/*
 * Cursor overlay control: APB register bank for the text and graphic
 * cursors, frame based blink timer, and a one stage overlay that
 * composites the graphic cursor while scan reversal is off, or the text cursor while graphic enable is off, into the pixel stream going to the panel.
 * Assumes the display pipeline supplies a pixel stream with x/y
 * coordinates, a one cycle frame start pulse at vertical sync, and
 * the text cursor position from the text engine, all on clk_sys.
 */
`timescale 1ns/1ps
module coc_cursor_overlay
   import coc_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // display pipeline
   input  wire logic        frame_start,
   input  wire logic [12:0] text_cur_x,
   input  wire logic [12:0] text_cur_y,
   input  wire coc_pix_t    pix_in,
   output coc_pix_t         pix_out
);

   // register state
   logic [7:0]  blink_period_q;
   logic [4:0]  tw_q;
   logic [4:0]  th_q;
   logic [12:0] gx_q;
   logic [12:0] gy_q;
   logic [7:0]  col_a_q;
   logic [7:0]  col_b_q;
   logic        gfx_en_q;
   coc_shape_t  gfx_sel_q;
   logic        txt_en_q;
   logic        blink_en_q;
   logic        vrev_q;
   logic [1:0]  enl_h_q;
   logic [1:0]  enl_v_q;

   // blink state
   logic [7:0]  frame_cnt_q;
   logic        blink_vis_q;

   // bus state
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic [31:0] rd_d;
   logic        hit_d;
   logic [6:0]  idx;
   logic        setup;
   logic        wr_en;
   logic [7:0]  wb;

   // overlay signals
   logic        gfx_act;
   logic        txt_act;
   logic        txt_show;
   logic [12:0] gdx;
   logic [12:0] gdy;
   logic        g_hit;
   logic [1:0]  g_code;
   logic [7:0]  tw_eff;
   logic [7:0]  th_eff;
   logic [12:0] tdx;
   logic [12:0] tdy;
   logic        t_hit;
   coc_pix_t    pix_d;
   coc_pix_t    pix_q;

   // bus decode; only word aligned addresses inside the window are mapped
   assign idx   = paddr[8:2];
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;
   assign wb    = pwdata[7:0];

   // read mux, unmapped indices flag an error and read zero
   always_comb
   begin
      rd_d  = 32'h0000_0000;
      hit_d = (paddr[1:0] == 2'h0) && (paddr[11:9] == 3'h0);
      case (idx)
         COC_IDX_SCAN:  rd_d[COC_SCAN_VREV] = vrev_q;
         COC_IDX_CTRL:
         begin
            rd_d[COC_CTRL_BLINK_EN] = blink_en_q;
            rd_d[COC_CTRL_TXT_EN]   = txt_en_q;
            rd_d[COC_CTRL_SEL_LO +: 2] = gfx_sel_q;
            rd_d[COC_CTRL_GFX_EN]   = gfx_en_q;
         end
         COC_IDX_BLINK: rd_d[7:0] = blink_period_q;
         COC_IDX_TW:    rd_d[4:0] = tw_q;
         COC_IDX_TH:    rd_d[4:0] = th_q;
         COC_IDX_XL:    rd_d[7:0] = gx_q[7:0];
         COC_IDX_XH:    rd_d[4:0] = gx_q[12:8];
         COC_IDX_YL:    rd_d[7:0] = gy_q[7:0];
         COC_IDX_YH:    rd_d[4:0] = gy_q[12:8];
         COC_IDX_CA:    rd_d[7:0] = col_a_q;
         COC_IDX_CB:    rd_d[7:0] = col_b_q;
         COC_IDX_ENL:
         begin
            rd_d[COC_ENL_H_LO +: 2] = enl_h_q;
            rd_d[COC_ENL_V_LO +: 2] = enl_v_q;
         end
         COC_IDX_STAT:
         begin
            rd_d[0]    = blink_vis_q;
            rd_d[1]    = gfx_act;
            rd_d[2]    = txt_show;
            rd_d[15:8] = frame_cnt_q;
         end
         default:       hit_d = 1'b0;
      endcase
   end

   // apb answer: sampled in setup, ready for exactly one access cycle
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         pready_q  <= setup;
         pslverr_q <= setup && !hit_d;
         if (setup)
            prdata_q <= (pwrite || !hit_d) ? 32'h0000_0000 : rd_d; // refused reads give 0
      end
   end

   // cursor control bits
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         gfx_en_q   <= 1'b0;
         gfx_sel_q  <= COC_SET_ARROW;
         txt_en_q   <= 1'b0;
         blink_en_q <= 1'b0;
         vrev_q     <= 1'b0;
         enl_h_q    <= 2'h0;
         enl_v_q    <= 2'h0;
      end
      else if (wr_en)
      begin
         if (idx == COC_IDX_CTRL)
         begin
            gfx_en_q   <= wb[COC_CTRL_GFX_EN];
            gfx_sel_q  <= coc_shape_t'(wb[COC_CTRL_SEL_LO +: 2]);
            txt_en_q   <= wb[COC_CTRL_TXT_EN];
            blink_en_q <= wb[COC_CTRL_BLINK_EN];
         end
         if (idx == COC_IDX_SCAN)
            vrev_q <= wb[COC_SCAN_VREV];
         if (idx == COC_IDX_ENL)
         begin
            enl_h_q <= wb[COC_ENL_H_LO +: 2];
            enl_v_q <= wb[COC_ENL_V_LO +: 2];
         end
      end
   end

   // text cursor size and blink period; size bits 7..5 are not stored
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         blink_period_q <= COC_RST_BLINK;
         tw_q           <= COC_RST_TW;
         th_q           <= COC_RST_TH;
      end
      else if (wr_en)
      begin
         if (idx == COC_IDX_BLINK)
            blink_period_q <= wb;
         if (idx == COC_IDX_TW)
            tw_q <= wb[4:0];
         if (idx == COC_IDX_TH)
            th_q <= wb[4:0];
      end
   end

   // graphic cursor position, each byte written on its own
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         gx_q <= COC_RST_POS;
         gy_q <= COC_RST_POS;
      end
      else if (wr_en)
      begin
         if (idx == COC_IDX_XL)
            gx_q[7:0] <= wb;
         if (idx == COC_IDX_XH)
            gx_q[12:8] <= wb[4:0];
         if (idx == COC_IDX_YL)
            gy_q[7:0] <= wb;
         if (idx == COC_IDX_YH)
            gy_q[12:8] <= wb[4:0];
      end
   end

   // graphic cursor colours, kept as packed RRRGGGBB
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         col_a_q <= COC_RST_COL;
         col_b_q <= COC_RST_COL;
      end
      else if (wr_en)
      begin
         if (idx == COC_IDX_CA)
            col_a_q <= wb;
         if (idx == COC_IDX_CB)
            col_b_q <= wb;
      end
   end

   // blink timer: a phase lasts period+1 frames, restarted when blink is off
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         frame_cnt_q <= 8'h00;
         blink_vis_q <= 1'b1;
      end
      else if (!blink_en_q)
      begin
         frame_cnt_q <= 8'h00;
         blink_vis_q <= 1'b1;
      end
      else if (frame_start)
      begin
         if (frame_cnt_q == blink_period_q)
         begin
            frame_cnt_q <= 8'h00;
            blink_vis_q <= !blink_vis_q;
         end
         else
            frame_cnt_q <= frame_cnt_q + 8'h01;
      end
   end

   // cursor arbitration; graphic enable alone silences the text cursor
   assign gfx_act  = gfx_en_q && !vrev_q;
   assign txt_act  = txt_en_q && !gfx_en_q;
   assign txt_show = txt_act && blink_vis_q;

   // graphic cursor hit test over its 32x32 square
   assign gdx   = pix_in.x - gx_q;
   assign gdy   = pix_in.y - gy_q;
   assign g_hit = (pix_in.x >= gx_q) && (pix_in.y >= gy_q)
                  && (gdx < COC_GFX_DIM) && (gdy < COC_GFX_DIM);

   coc_shape u_shape
   (
      .dx   (gdx[4:0]),
      .sel  (gfx_sel_q),
      .dy   (gdy[4:0]),
      .code (g_code)
   );

   // text cursor size after enlargement, at most 32 x 4 = 128 pixels
   assign tw_eff = 8'((6'(tw_q) + 6'h01) * (3'(enl_h_q) + 3'h1));
   assign th_eff = 8'((6'(th_q) + 6'h01) * (3'(enl_v_q) + 3'h1));
   assign tdx    = pix_in.x - text_cur_x;
   assign tdy    = pix_in.y - text_cur_y;
   assign t_hit  = (pix_in.x >= text_cur_x) && (pix_in.y >= text_cur_y)
                   && (tdx < {5'h00, tw_eff}) && (tdy < {5'h00, th_eff});

   // composite: graphic colours replace, text cursor inverts the pixel
   always_comb
   begin
      pix_d = pix_in;
      if (gfx_act && g_hit && (g_code == COC_SHP_A))
         pix_d.rgb = col_a_q;
      else if (gfx_act && g_hit && (g_code == COC_SHP_B))
         pix_d.rgb = col_b_q;
      else if (txt_show && t_hit)
         pix_d.rgb = ~pix_in.rgb;
   end

   // one stage of latency keeps the panel output straight from a flop
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         pix_q <= '0;
      else
         pix_q <= pix_d;
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign pix_out = pix_q;

endmodule // coc_cursor_overlay

// [coc_cursor_overlay_sva.sv]
/* port checker for the cursor overlay bank.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module coc_sva
   import coc_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // write completing, then a read setup, to one index
   sequence s_wr(logic [6:0] i);
      psel && penable && pready && pwrite && paddr[8:2] == i;
   endsequence
   sequence s_rs(logic [6:0] i);
      psel && !penable && !pwrite && paddr[8:2] == i;
   endsequence
   property p_back(logic [6:0] i);
      s_wr(i) ##1 s_rs(i) ##1 pready |-> prdata[7:0] == $past(pwdata[7:0], 2);
   endproperty
   // only five low bits may ever read back
   property p_top0(logic [6:0] i);
      pready && !pwrite && paddr[8:2] == i |-> prdata[31:5] == 27'h0;
   endproperty
   a_ready_follows: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   a_err_misalign: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 0)
      else $error("misaligned access not refused");
   a_blink_back: assert property (p_back(COC_IDX_BLINK))
      else $error("blink period lost");
   a_colour_a_back: assert property (p_back(COC_IDX_CA))
      else $error("colour a lost");
   a_colour_b_back: assert property (p_back(COC_IDX_CB))
      else $error("colour b lost");
   a_width_top0: assert property (p_top0(COC_IDX_TW))
      else $error("width top bits set");
   a_height_top0: assert property (p_top0(COC_IDX_TH))
      else $error("height top bits set");
   a_xhigh_top0: assert property (p_top0(COC_IDX_XH))
      else $error("x high top bits set");
   a_yhigh_top0: assert property (p_top0(COC_IDX_YH))
      else $error("y high top bits set");
endmodule // coc_sva

bind coc_cursor_overlay coc_sva u_coc_sva (.clk_sys, .rst_n, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr);

// [coc_panel.sv]
/* panel model taking the composited pixels.
   assumes pixels arrive one per clk_sys edge. */
`timescale 1ns/1ps
module coc_panel
   import coc_pkg::*;
(
   input  wire logic     clk_sys,
   input  wire coc_pix_t pix,
   output logic [7:0]    rgb_q
);
   // keep the colour of each valid pixel
   always_ff @(posedge clk_sys)
   begin
      if (pix.valid)
         rgb_q <= pix.rgb;
   end
endmodule // coc_panel

// [test_cursor_overlay_control.sv]
/* self-checking bench for the cursor overlay bank.
   assumes it is the apb host, pixel source and frame timer. */
`timescale 1ns/1ps
module test_cursor_overlay_control
   import coc_pkg::*;
;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        frame_start = 1'b0;
   logic [12:0] tx = 13'h0064;
   logic [12:0] ty = 13'h0032;
   coc_pix_t    pix_in = '0;
   coc_pix_t    pix_out;
   logic [7:0]  rgb_q;
   logic [31:0] r;
   logic        e;
   logic [7:0]  po;
   int          err_count = 0;
   int          checked = 0;
   int          cyc = 0;
   localparam logic [7:0] RST [9] = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                     8'h00, 8'h00};
   localparam logic [6:0] TOP [4] = '{COC_IDX_TW, COC_IDX_TH, COC_IDX_XH, COC_IDX_YH};
   localparam logic [6:0] FUL [5] = '{COC_IDX_BLINK, COC_IDX_XL, COC_IDX_YL, COC_IDX_CA,
                                     COC_IDX_CB};
   localparam logic [1:0] SHP [2][4] = '{'{2'h2, 2'h0, 2'h0, 2'h1}, '{2'h0, 2'h1, 2'h2, 2'h2}};
`define CHK(a, b) check((a) === (b));

   coc_cursor_overlay u_coc_cursor_overlay (.clk_sys, .rst_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .frame_start, .text_cur_x(tx),
      .text_cur_y(ty), .pix_in, .pix_out);
   coc_panel u_coc_panel (.clk_sys, .pix(pix_out), .rgb_q);

   always #10 clk_sys = ~clk_sys;

   // hang guard, far past the few hundred cycles needed
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("err_count=%0d checked=%0d", err_count, checked);
      if (err_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(input logic ok);
      checked++;
      if (!ok)
      begin
         err_count++;
         $display("MISMATCH %0t compare failed", $time);
      end
   endtask

   function automatic logic [11:0] ad(input logic [6:0] i);
      return {3'h0, i, 2'h0};
   endfunction

   // request held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      // answer taken at the very edge that shows pready, release left to the caller
      do
         @(posedge clk_sys);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
   endtask

   task automatic idle();
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic wr(input logic [6:0] i, input logic [7:0] d);
      apb(1'b1, ad(i), d);
      idle();
   endtask

   task automatic rd(input logic [6:0] i);
      apb(1'b0, ad(i), 8'h00);
      idle();
   endtask

   // one pixel in, the colour the panel latched for it out
   task automatic px(input int x, input int y, input logic [7:0] c);
      pix_in <= '{1'b1, 13'(x), 13'(y), c};
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      po = rgb_q;
      @(posedge clk_sys);
   endtask

   task automatic frame();
      frame_start <= 1'b1;
      @(posedge clk_sys);
      frame_start <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask

   function automatic logic [7:0] txt_exp(input int x, y, xw, yh, input logic [7:0] c);
      return (x >= tx && x < tx + xw && y >= ty && y < ty + yh) ? ~c : c;
   endfunction

   function automatic logic [7:0] gfx_exp(input logic [1:0] k, input logic [7:0] a, b, c);
      return k == 2'h1 ? a : k == 2'h2 ? b : c;
   endfunction

   initial
   begin
      logic [7:0]  v;
      logic [7:0]  ca;
      logic [12:0] p;
      logic [13:0] cfg;
      int          xw;
      int          yh;
      int          qx [4];
      int          qy [4];
      v = 8'($urandom(66061));
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      // reset values of the bank
      foreach (RST[i])
      begin
         rd(COC_IDX_BLINK + 7'(i));
         `CHK(r[7:0], RST[i])
      end
      // unused top bits drop on write
      foreach (TOP[i])
      begin
         v = 8'($urandom);
         wr(TOP[i], v | 8'hE0);
         rd(TOP[i]);
         `CHK(r, {27'h0, v[4:0]})
      end
      // full bytes read straight after the write
      foreach (FUL[i])
      begin
         v = 8'($urandom);
         apb(1'b1, ad(FUL[i]), v);
         apb(1'b0, ad(FUL[i]), 8'h00);
         idle();
         `CHK(r[7:0], v)
      end
      // unmapped index and misaligned address are refused
      rd(7'h7F);
      `CHK({e, r}, {1'b1, 32'h0})
      apb(1'b0, ad(COC_IDX_TW) | 12'h001, 8'h00);
      idle();
      `CHK({e, r}, {1'b1, 32'h0})
      // text box edges, largest size first then random sizes
      for (int n = 0; n < 4; n++)
      begin
         cfg = n == 0 ? 14'h3FFF : 14'($urandom);
         wr(COC_IDX_TW, {3'h0, cfg[13:9]});
         wr(COC_IDX_TH, {3'h0, cfg[8:4]});
         wr(COC_IDX_ENL, {4'h0, cfg[3:0]});
         wr(COC_IDX_CTRL, 8'h02);
         xw = (cfg[13:9] + 1) * (cfg[1:0] + 1);
         yh = (cfg[8:4] + 1) * (cfg[3:2] + 1);
         qx = '{xw - 1, xw, 0, -1};
         qy = '{yh - 1, 0, yh, 0};
         for (int k = 0; k < 4; k++)
         begin
            v = 8'($urandom);
            px(tx + qx[k], ty + qy[k], v);
            `CHK(po, txt_exp(tx + qx[k], ty + qy[k], xw, yh, v))
         end
      end
      // every shape set at a diagonal point and a top edge point
      ca = 8'($urandom);
      wr(COC_IDX_CA, ca);
      wr(COC_IDX_CB, ~ca);
      p = 13'($urandom_range(8000, 300));
      foreach (FUL[i])
         if (i == 1 || i == 2)
         begin
            wr(FUL[i], p[7:0]);
            wr(FUL[i] + 7'h01, {3'h0, p[12:8]});
         end
      // both enables: text gives way; square now sits well clear of the text box
      wr(COC_IDX_CTRL, 8'h12);
      px(tx, ty, v);
      `CHK(po, v)
      v = ca ^ 8'h0F;
      for (int s = 0; s < 4; s++)
      begin
         wr(COC_IDX_CTRL, 8'h10 | 8'(s << 2));
         for (int k = 0; k < 2; k++)
         begin
            px(p + 5 + 11 * k, p + 5 - 5 * k, v);
            `CHK(po, gfx_exp(SHP[k][s], ca, ~ca, v))
         end
      end
      // scan reversal hides the graphic cursor
      wr(COC_IDX_SCAN, 8'h08);
      px(p + 5, p + 5, v);
      `CHK(po, v)
      wr(COC_IDX_SCAN, 8'h00);
      // blink phase is period plus one frames
      for (int n = 0; n < 2; n++)
      begin
         v = n == 0 ? 8'h00 : 8'($urandom_range(6, 1));
         wr(COC_IDX_BLINK, v);
         wr(COC_IDX_CTRL, 8'h02);
         frame();
         rd(COC_IDX_STAT);
         `CHK(r[0], 1'b1)
         wr(COC_IDX_CTRL, 8'h03);
         repeat (v) frame();
         rd(COC_IDX_STAT);
         `CHK(r[0], 1'b1)
         frame();
         rd(COC_IDX_STAT);
         `CHK(r[0], 1'b0)
      end
      end_sim();
   end
endmodule // test_cursor_overlay_control
